// file: hdl/cmc_channel_top.sv
// Purpose: operating modes and external channel of a 32-bit processor
// Assumes: all inputs except ARST_N synchronous to CLK_SYS; pins resolved outside
// Notes:   data has priority on the shared address bus
//
// Behaviour
// - Wait mode stops execution and starts no channel access.
// - Enabled interrupt or reset ends wait mode.
// - Interlock stalls execution in hold until it may proceed.
// - Halt mode performs no fetch and no execution.
// - Halt entered by halting instruction or external request.
// - Step acts as halt; each step gives one executing cycle.
// - Load-test mode executes instructions driven onto instruction bus.
// - Fetch state is kept so normal sequence resumes after test.
// - Test mode disables all output drivers.
// - Reset mode initialises control state for all reset uses.
// - Current operating mode is always shown on status outputs.
// - Inbound instruction, two-way data and shared address buses.
// - Simple access holds address stable until its reply.
// - Pipelined access allows one extra address before reply.
// - Burst advances address by one word without address cycle.
// - Either side may end a burst; both honour the other.
// - Responder may turn simple data access into pipelined, instruction fetch into burst.
// - Protocol chosen per transfer by the core.
// - Data accesses run beside an instruction burst.
// - Arbitration lets an external master take the channel.
// - Enabled outputs compared with pins; mismatch flags error.
// - Coprocessor transfer uses own space, both buses, 64 bits.
// - Privilege output high for supervisor during address cycle.
`default_nettype none

module cmc_channel_top
	import cmc_pkg::*;
(
	// Clock and reset
	input  wire logic              CLK_SYS,
	input  wire logic              ARST_N,
	// Mode controls
	input  wire logic              RESET_REQ,
	input  wire logic              TEST_REQ,
	input  wire logic              HALT_REQ,
	input  wire logic              STEP_REQ,
	input  wire logic              STEP_GO,
	input  wire logic              LTI_REQ,
	// Core events
	input  wire logic              HALT_INSTR,
	input  wire logic              WAIT_ENTER,
	input  wire logic              INTR_REQ,
	input  wire logic              CORE_HAZARD,
	input  wire logic              CORE_NEED_INSTR,
	input  wire logic              SUPERVISOR,
	// Mode status
	output logic [2:0]             MODE_STATUS,
	output logic                   EXEC_EN,
	// Core instruction side
	input  wire logic              CORE_IFREE,
	input  wire logic              CORE_BRANCH,
	input  wire logic [BUS_W-1:0]  CORE_BRANCH_ADDR,
	output logic [BUS_W-1:0]       CORE_INSTR,
	output logic                   CORE_INSTR_VALID,
	// Core data side
	input  wire logic              CORE_DREQ,
	input  wire logic              CORE_DWRITE,
	input  wire logic [1:0]        CORE_DKIND,
	input  wire logic              CORE_DCOP,
	input  wire logic              CORE_DMORE,
	input  wire logic [BUS_W-1:0]  CORE_DADDR,
	input  wire logic [BUS_W-1:0]  CORE_DWDATA,
	input  wire logic [BUS_W-1:0]  CORE_COP_OPND,
	output logic                   CORE_DACK,
	output logic [BUS_W-1:0]       CORE_DRDATA,
	output logic                   CORE_DVALID,
	// Channel buses
	output logic [BUS_W-1:0]       ADDR_O,
	output logic                   ADDR_OE,
	input  wire logic [BUS_W-1:0]  ADDR_PIN,
	input  wire logic [BUS_W-1:0]  INSTR_I,
	output logic [BUS_W-1:0]       DATA_O,
	output logic                   DATA_OE,
	input  wire logic [BUS_W-1:0]  DATA_I,
	// Channel controls
	output logic                   IREQ_O,
	output logic                   IBREQ_O,
	output logic                   DREQ_O,
	output logic                   DBREQ_O,
	output logic                   RW_O,
	output logic                   COP_O,
	output logic                   PRIV_LEVEL_OUT,
	output logic                   CTRL_OE,
	input  wire logic [CTRL_W-1:0] CTRL_PIN,
	// Channel responses
	input  wire logic              IRDY_I,
	input  wire logic              IBACK_I,
	input  wire logic              DRDY_I,
	input  wire logic              DBACK_I,
	input  wire logic              DPIPE_I,
	// Arbitration and checking
	input  wire logic              BREQ_I,
	output logic                   BGRANT_O,
	output logic                   OUT_ERR
);

	cmc_mode_if mif ();

	cmc_ifetch_type   i_state;
	logic [BUS_W-1:0] ipc;
	logic             i_sup;
	logic             i_cont;
	logic             i_issue;
	logic             i_beat;
	logic             hazard;

	logic             d_addr;
	logic             d_burst;
	logic             d_piped;
	logic [1:0]       d_out;
	logic [BUS_W-1:0] d_adr;
	logic [BUS_W-1:0] d_wdata;
	logic [BUS_W-1:0] d_opnd;
	logic [1:0]       d_kind;
	logic             d_write;
	logic             d_cop;
	logic             d_sup;
	logic             d_issue;
	logic             d_beat;
	logic             d_cont;
	logic             d_end;

	logic             chan_free;
	logic             drive;
	logic             check_en;
	logic [2:0]       err_vec;

	// Interlock: missing instruction counts as a hazard
	assign hazard = CORE_HAZARD || (CORE_NEED_INSTR && !CORE_INSTR_VALID);

	cmc_mode_ctl u_mode (
		.clk        (CLK_SYS),
		.arst_n     (ARST_N),
		.reset_req  (RESET_REQ),
		.test_req   (TEST_REQ),
		.halt_req   (HALT_REQ),
		.step_req   (STEP_REQ),
		.step_go    (STEP_GO),
		.lti_req    (LTI_REQ),
		.halt_instr (HALT_INSTR),
		.wait_enter (WAIT_ENTER),
		.intr_req   (INTR_REQ),
		.hazard     (hazard),
		.mif        (mif)
	);

	assign EXEC_EN = mif.exec_en;

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			MODE_STATUS <= STAT_RESET;
		end else begin
			unique case (mif.mode)
				MODE_RESET: MODE_STATUS <= STAT_RESET;
				MODE_EXEC:  MODE_STATUS <= STAT_EXEC;
				MODE_WAIT:  MODE_STATUS <= STAT_WAIT;
				MODE_HOLD:  MODE_STATUS <= STAT_HOLD;
				MODE_HALT:  MODE_STATUS <= STAT_HALT;
				MODE_STEP:  MODE_STATUS <= STAT_STEP;
				MODE_LTI:   MODE_STATUS <= STAT_LTI;
				MODE_TEST:  MODE_STATUS <= STAT_TEST;
			endcase
		end
	end

	// external master arbitration
	// Requests stop once BREQ_I rises, so the grant cannot race an issue
	assign chan_free = !BGRANT_O && !BREQ_I;

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			BGRANT_O <= 1'b0;
		end else if (mif.chan_clr || !BREQ_I) begin
			BGRANT_O <= 1'b0;
		end else if (i_state == I_IDLE && !d_addr && !d_burst
		             && d_out == OUT_NONE) begin
			BGRANT_O <= 1'b1;
		end
	end

	// Instruction side
	assign i_cont  = mif.fetch_en && CORE_IFREE && !CORE_BRANCH;
	// data address first; fetch waits only on shared address bus
	assign i_issue = (i_state == I_IDLE) && i_cont && chan_free
	                 && !d_addr && !d_issue;
	assign i_beat  = IRDY_I && (i_state != I_IDLE);

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			i_state <= I_IDLE;
		end else if (mif.chan_clr || CORE_BRANCH) begin
			i_state <= I_IDLE;
		end else begin
			unique case (i_state)
				I_IDLE: begin
					if (i_issue) begin
						i_state <= I_ADDR;
					end
				end
				I_ADDR: begin
					if (IBACK_I && i_cont) begin
						i_state <= I_BURST;
					end else if (IRDY_I || !i_cont) begin
						i_state <= I_IDLE;
					end
				end
				I_BURST: begin
					if (!IBACK_I || !i_cont) begin
						i_state <= I_IDLE;
					end
				end
			endcase
		end
	end

	// fetch pointer untouched outside fetch, so execution resumes
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			ipc <= RESET_VECTOR;
		end else if (mif.chan_clr) begin
			ipc <= RESET_VECTOR;
		end else if (CORE_BRANCH) begin
			ipc <= CORE_BRANCH_ADDR;
		end else if (i_beat) begin
			ipc <= ipc + WORD_STEP;
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			i_sup <= 1'b0;
		end else if (i_issue) begin
			i_sup <= SUPERVISOR;
		end
	end

	// test instructions taken from the instruction bus
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			CORE_INSTR       <= '0;
			CORE_INSTR_VALID <= 1'b0;
		end else begin
			CORE_INSTR_VALID <= (i_beat && !CORE_BRANCH)
			                    || (mif.lti && IRDY_I);
			if (i_beat || (mif.lti && IRDY_I)) begin
				CORE_INSTR <= INSTR_I;
			end
		end
	end

	// Data side
	// kind taken per transfer
	// one extra address only after pipelined acceptance
	assign d_issue = CORE_DREQ && mif.access_en && chan_free
	                 && !d_addr && !d_burst && (i_state != I_ADDR)
	                 && (d_out == OUT_NONE
	                     || (d_out == OUT_ONE && d_piped
	                         && CORE_DKIND == KIND_PIPE));
	assign CORE_DACK = d_issue;
	assign d_beat    = DRDY_I && (d_out != OUT_NONE);
	assign d_cont    = DBACK_I && CORE_DMORE && mif.access_en
	                   && (d_kind == KIND_BURST) && !d_cop;
	// Burst ends on a beat where either side withdraws
	assign d_end     = d_beat && !(d_burst && d_cont)
	                   && !(d_addr && d_cont);

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			d_addr  <= 1'b0;
			d_burst <= 1'b0;
			d_piped <= 1'b0;
		end else if (mif.chan_clr) begin
			d_addr  <= 1'b0;
			d_burst <= 1'b0;
			d_piped <= 1'b0;
		end else if (d_issue) begin
			d_addr  <= 1'b1;
			d_piped <= 1'b0;
		end else if (d_addr) begin
			// address held until reply or conversion
			if (d_cont) begin
				d_addr  <= 1'b0;
				d_burst <= 1'b1;
			end else if (DRDY_I) begin
				d_addr <= 1'b0;
			end else if (DPIPE_I) begin
				d_addr  <= 1'b0;
				d_piped <= 1'b1;
			end
		end else if (d_burst && d_beat && !d_cont) begin
			d_burst <= 1'b0;
		end else if (d_end && d_out == OUT_ONE) begin
			d_piped <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			d_out <= OUT_NONE;
		end else if (mif.chan_clr) begin
			d_out <= OUT_NONE;
		end else if (d_issue && !d_end) begin
			d_out <= d_out + OUT_ONE;
		end else if (d_end && !d_issue) begin
			d_out <= d_out - OUT_ONE;
		end
	end

	// coprocessor operand rides on the address bus
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			d_adr   <= RESET_VECTOR;
			d_wdata <= '0;
			d_opnd  <= '0;
			d_kind  <= KIND_SIMPLE;
			d_write <= 1'b0;
			d_cop   <= 1'b0;
			d_sup   <= 1'b0;
		end else if (d_issue) begin
			d_adr   <= CORE_DADDR;
			d_wdata <= CORE_DWDATA;
			d_opnd  <= CORE_COP_OPND;
			d_kind  <= CORE_DKIND;
			d_write <= CORE_DWRITE;
			d_cop   <= CORE_DCOP;
			d_sup   <= SUPERVISOR;
		end else if (d_beat && d_cont && (d_burst || d_addr)) begin
			d_adr   <= d_adr + WORD_STEP;
			d_wdata <= CORE_DWDATA;
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			CORE_DRDATA <= '0;
			CORE_DVALID <= 1'b0;
		end else begin
			CORE_DVALID <= d_beat;
			if (d_beat && !d_write) begin
				CORE_DRDATA <= DATA_I;
			end
		end
	end

	// Channel pins
	// drivers off in test mode and while granted away
	assign drive   = mif.drive_en && !BGRANT_O;
	assign ADDR_OE = drive;
	assign CTRL_OE = drive;
	assign DATA_OE = drive && d_write && (d_out != OUT_NONE);
	assign DATA_O  = d_wdata;

	// one address bus shared by both sides
	assign ADDR_O = d_addr ? (d_cop ? d_opnd : d_adr) : ipc;

	assign IREQ_O  = (i_state == I_ADDR);
	assign IBREQ_O = (i_state != I_IDLE) && i_cont;
	assign DREQ_O  = d_addr;
	assign DBREQ_O = (d_addr || d_burst) && d_cont;
	assign RW_O    = d_write;
	assign COP_O   = d_cop;

	// privilege of the address cycle owner
	assign PRIV_LEVEL_OUT = d_addr ? d_sup : i_sup;

	// A disabled second unit still compares against the pins
	assign check_en = drive || mif.test;

	cmc_out_check #(.W(BUS_W)) u_chk_addr (
		.clk      (CLK_SYS),
		.arst_n   (ARST_N),
		.check_en (check_en),
		.drv      (ADDR_O),
		.pin      (ADDR_PIN),
		.mismatch (err_vec[0])
	);

	cmc_out_check #(.W(BUS_W)) u_chk_data (
		.clk      (CLK_SYS),
		.arst_n   (ARST_N),
		.check_en (check_en && d_write && (d_out != OUT_NONE)),
		.drv      (DATA_O),
		.pin      (DATA_I),
		.mismatch (err_vec[1])
	);

	cmc_out_check #(.W(CTRL_W)) u_chk_ctrl (
		.clk      (CLK_SYS),
		.arst_n   (ARST_N),
		.check_en (check_en),
		.drv      ({IREQ_O, IBREQ_O, DREQ_O, DBREQ_O,
		            RW_O, COP_O, PRIV_LEVEL_OUT}),
		.pin      (CTRL_PIN),
		.mismatch (err_vec[2])
	);

	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			OUT_ERR <= 1'b0;
		end else begin
			OUT_ERR <= |err_vec;
		end
	end

endmodule : cmc_channel_top

`default_nettype wire

// file: hdl/cmc_pkg.sv
// Purpose: shared types and constants of the mode and channel block
// Assumes: 32-bit channel buses, one system clock
// Notes:   status codes and word step are fixed encodings
`default_nettype none

package cmc_pkg;

	localparam int          BUS_W        = 32;
	localparam int          CTRL_W       = 7;
	localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
	localparam logic [31:0] WORD_STEP    = 32'h0000_0004;

	// Per-transfer protocol chosen by the core
	localparam logic [1:0]  KIND_SIMPLE  = 2'h0;
	localparam logic [1:0]  KIND_PIPE    = 2'h1;
	localparam logic [1:0]  KIND_BURST   = 2'h2;

	// Outstanding data access counts
	localparam logic [1:0]  OUT_NONE     = 2'h0;
	localparam logic [1:0]  OUT_ONE      = 2'h1;

	// External mode status codes
	localparam logic [2:0]  STAT_EXEC    = 3'h0;
	localparam logic [2:0]  STAT_WAIT    = 3'h1;
	localparam logic [2:0]  STAT_HOLD    = 3'h2;
	localparam logic [2:0]  STAT_HALT    = 3'h3;
	localparam logic [2:0]  STAT_STEP    = 3'h4;
	localparam logic [2:0]  STAT_LTI     = 3'h5;
	localparam logic [2:0]  STAT_TEST    = 3'h6;
	localparam logic [2:0]  STAT_RESET   = 3'h7;

	typedef enum logic [2:0] {
		MODE_RESET,
		MODE_EXEC,
		MODE_WAIT,
		MODE_HOLD,
		MODE_HALT,
		MODE_STEP,
		MODE_LTI,
		MODE_TEST
	} cmc_mode_type;

	typedef enum logic [1:0] {
		I_IDLE,
		I_ADDR,
		I_BURST
	} cmc_ifetch_type;

endpackage : cmc_pkg

`default_nettype wire

// file: hdl/cmc_mode_if.sv
// Purpose: mode state passed from the mode controller to the channel
// Assumes: single clock domain
// Notes:   all enables are decoded from the registered mode, exec_en also from hazard
`default_nettype none

interface cmc_mode_if;
	import cmc_pkg::*;

	cmc_mode_type mode;
	logic         exec_en;
	logic         fetch_en;
	logic         access_en;
	logic         drive_en;
	logic         chan_clr;
	logic         lti;
	logic         test;

	modport ctl  (output mode, exec_en, fetch_en, access_en,
	              output drive_en, chan_clr, lti, test);
	modport user (input mode, exec_en, fetch_en, access_en,
	              input drive_en, chan_clr, lti, test);
endinterface : cmc_mode_if

`default_nettype wire

// file: hdl/cmc_out_check.sv
// Purpose: compares driven output values with pin levels
// Assumes: pin levels are synchronous to the clock
// Notes:   mismatch is registered, one cycle after the compare
`default_nettype none

module cmc_out_check
	import cmc_pkg::*;
#(
	parameter int W = 32
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         arst_n,
	// Compare
	input  wire logic         check_en,
	input  wire logic [W-1:0] drv,
	input  wire logic [W-1:0] pin,
	output logic              mismatch
);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mismatch <= 1'b0;
		end else begin
			mismatch <= check_en && (drv != pin);
		end
	end

endmodule : cmc_out_check

`default_nettype wire

// file: hdl/cmc_mode_ctl.sv
// Purpose: operating mode controller
// Assumes: requests are synchronous levels, step_go a level that
//          advances once per rising edge
// Notes:   halt by instruction stays until a reset
`default_nettype none

module cmc_mode_ctl
	import cmc_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// External controls
	input  wire logic reset_req,
	input  wire logic test_req,
	input  wire logic halt_req,
	input  wire logic step_req,
	input  wire logic step_go,
	input  wire logic lti_req,
	// Core events
	input  wire logic halt_instr,
	input  wire logic wait_enter,
	input  wire logic intr_req,
	input  wire logic hazard,
	// Mode out
	cmc_mode_if.ctl   mif
);

	cmc_mode_type mode;
	cmc_mode_type next_mode;
	logic         halt_latch;
	logic         wait_latch;
	logic         step_go_q;
	logic         step_pulse;

	assign step_pulse = step_go && !step_go_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			step_go_q <= 1'b0;
		end else begin
			step_go_q <= step_go;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			halt_latch <= 1'b0;
		end else if (reset_req) begin
			halt_latch <= 1'b0;
		end else if (halt_instr) begin
			halt_latch <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wait_latch <= 1'b0;
		end else if (reset_req || intr_req) begin
			wait_latch <= 1'b0;
		end else if (wait_enter) begin
			wait_latch <= 1'b1;
		end
	end

	always_comb begin
		if (reset_req) begin
			next_mode = MODE_RESET;
		end else if (test_req) begin
			next_mode = MODE_TEST;
		end else if (step_req) begin
			next_mode = step_pulse ? MODE_EXEC : MODE_STEP;
		end else if (halt_req || halt_latch) begin
			next_mode = MODE_HALT;
		end else if (lti_req) begin
			next_mode = MODE_LTI;
		end else if (wait_latch && !intr_req) begin
			next_mode = MODE_WAIT;
		end else if (hazard) begin
			next_mode = MODE_HOLD;
		end else begin
			next_mode = MODE_EXEC;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode <= MODE_RESET;
		end else begin
			mode <= next_mode;
		end
	end

	assign mif.mode      = mode;
	assign mif.exec_en   = (mode == MODE_EXEC) && !hazard;
	assign mif.fetch_en  = (mode == MODE_EXEC) || (mode == MODE_HOLD);
	assign mif.access_en = mif.fetch_en || (mode == MODE_LTI);
	assign mif.drive_en  = (mode != MODE_TEST);
	assign mif.chan_clr  = (mode == MODE_RESET);
	assign mif.lti       = (mode == MODE_LTI);
	assign mif.test      = (mode == MODE_TEST);

endmodule : cmc_mode_ctl

`default_nettype wire

// file: tb/cmc_channel_assertions.sv
// Purpose: port checks on the mode and channel block
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every instance of the top module
`default_nettype none

module cmc_channel_assertions
	import cmc_pkg::*;
(
	// Clock, reset and mode
	input wire logic              CLK_SYS, ARST_N, RESET_REQ, TEST_REQ,
	input wire logic              STEP_REQ, STEP_GO, SUPERVISOR, EXEC_EN,
	input wire logic [2:0]        MODE_STATUS,
	// Channel
	input wire logic              DREQ_O, DRDY_I, DPIPE_I, DBACK_I, IBREQ_O,
	input wire logic              IRDY_I, IBACK_I, CORE_BRANCH, PRIV_LEVEL_OUT,
	input wire logic              ADDR_OE, DATA_OE, CTRL_OE, OUT_ERR, BGRANT_O,
	input wire logic [BUS_W-1:0]  ADDR_O,
	input wire logic [CTRL_W-1:0] CTRL_PIN
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking dck @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);

	property p_exec;
		EXEC_EN |=> MODE_STATUS == STAT_EXEC;
	endproperty
	a_exec: assert property (p_exec) else $error("exec outside mode");

	property p_step;
		STEP_REQ && $rose(STEP_GO) && MODE_STATUS == STAT_STEP ##1
		STEP_REQ [*2] |-> MODE_STATUS == STAT_EXEC ##1 MODE_STATUS == STAT_STEP;
	endproperty
	a_step: assert property (p_step) else $error("step not one cycle");

	property p_simple;
		DREQ_O && !DRDY_I && !DPIPE_I && !DBACK_I && !RESET_REQ
		|=> DREQ_O && $stable(ADDR_O);
	endproperty
	a_simple: assert property (p_simple) else $error("address moved");

	property p_burst;
		IBREQ_O && IRDY_I && IBACK_I && !DREQ_O && !CORE_BRANCH && !RESET_REQ
		|=> DREQ_O || ADDR_O == $past(ADDR_O) + WORD_STEP;
	endproperty
	a_burst: assert property (p_burst) else $error("burst step wrong");

	property p_test;
		TEST_REQ && !RESET_REQ |=> !ADDR_OE && !DATA_OE && !CTRL_OE;
	endproperty
	a_test: assert property (p_test) else $error("driving in test");

	property p_grant;
		BGRANT_O |-> !ADDR_OE && !CTRL_OE && !DATA_OE;
	endproperty
	a_grant: assert property (p_grant) else $error("driving granted");

	property p_err;
		CTRL_OE && CTRL_PIN[0] != PRIV_LEVEL_OUT |-> ##[1:2] OUT_ERR;
	endproperty
	a_err: assert property (p_err) else $error("mismatch missed");

	property p_priv;
		$rose(DREQ_O) |-> PRIV_LEVEL_OUT == $past(SUPERVISOR);
	endproperty
	a_priv: assert property (p_priv) else $error("privilege wrong");

	property p_reset;
		RESET_REQ |-> ##2 MODE_STATUS == STAT_RESET;
	endproperty
	a_reset: assert property (p_reset) else $error("reset not shown");
endmodule // cmc_channel_assertions

bind cmc_channel_top cmc_channel_assertions chk_u (.*);

`default_nettype wire

// file: tb/cmc_mem_model.sv
// Purpose: memory responder on the far side of the channel
// Assumes: replies launched 2 ns after the clock edge, after the bench
//          has driven its inputs, so burst requests are seen settled
// Notes:   undriven buses flip every cycle
`default_nettype none

module cmc_mem_model
	import cmc_pkg::*;
(
	// Clock and pace
	input  wire logic             clk,
	input  wire logic             slow,
	// Requests
	input  wire logic             ireq,
	input  wire logic             ibreq,
	input  wire logic             dreq,
	input  wire logic             rw,
	input  wire logic [BUS_W-1:0] addr,
	input  wire logic [BUS_W-1:0] wdata,
	// Replies
	output logic                  irdy,
	output logic [BUS_W-1:0]      instr,
	output logic                  drdy,
	output logic [BUS_W-1:0]      rdata
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [BUS_W-1:0] mem [logic [BUS_W-1:0]];
	logic [BUS_W-1:0] iaddr = '0;
	int               cnt = 0;

	initial {irdy, drdy, instr, rdata} = '0;

	always @(posedge clk) begin
		#2;
		if (irdy)
			iaddr = iaddr + WORD_STEP;
		if (ireq)
			iaddr = addr;
		irdy = ireq | ibreq;
		instr = irdy ? iaddr ^ 32'hffff_0000 : ~instr;
		cnt = (dreq && !drdy) ? cnt + 1 : 0;
		drdy = cnt >= (slow ? 4 : 2);
		if (drdy && rw)
			mem[addr] = wdata;
		rdata = ~rdata;
		if (drdy && !rw)
			rdata = mem.exists(addr) ? mem[addr] : ~addr;
	end
endmodule // cmc_mem_model

`default_nettype wire

// file: tb/tb.sv
// Purpose: self-checking bench for the mode and channel block
// Assumes: responder model answers every request
// Notes:   data bursts and coprocessor space are not exercised
`default_nettype none

module tb
	import cmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic CLK_SYS, ARST_N, RESET_REQ, TEST_REQ, HALT_REQ, STEP_REQ, STEP_GO;
	logic LTI_REQ, HALT_INSTR, WAIT_ENTER, INTR_REQ, CORE_HAZARD, SUPERVISOR;
	logic CORE_NEED_INSTR, EXEC_EN, CORE_INSTR_VALID, CORE_IFREE, CORE_BRANCH;
	logic CORE_DREQ, CORE_DWRITE, CORE_DCOP, CORE_DMORE, CORE_DACK, IREQ_O;
	logic CORE_DVALID, ADDR_OE, DATA_OE, IBREQ_O, DREQ_O, DBREQ_O, RW_O, COP_O;
	logic PRIV_LEVEL_OUT, CTRL_OE, IRDY_I, IBACK_I, DRDY_I, DBACK_I, DPIPE_I;
	logic BREQ_I, BGRANT_O, OUT_ERR, slow, fault;
	logic [1:0]        CORE_DKIND;
	logic [2:0]        MODE_STATUS;
	logic [CTRL_W-1:0] CTRL_PIN;
	logic [BUS_W-1:0]  CORE_BRANCH_ADDR, CORE_INSTR, CORE_DADDR, CORE_DWDATA;
	logic [BUS_W-1:0]  CORE_COP_OPND, CORE_DRDATA, ADDR_O, ADDR_PIN, INSTR_I;
	logic [BUS_W-1:0]  DATA_O, DATA_I, rdata;
	int                n_errors = 0;
	int                n_checks = 0;
	int                cyc = 0;

	assign ADDR_PIN = ADDR_O;
	assign DATA_I = DATA_OE ? DATA_O : rdata;
	assign CTRL_PIN = {IREQ_O, IBREQ_O, DREQ_O, DBREQ_O, RW_O, COP_O,
	                   PRIV_LEVEL_OUT ^ fault};
	assign IBACK_I = IRDY_I;
	assign DBACK_I = 1'b0;
	assign DPIPE_I = 1'b0;

	cmc_channel_top dut_u (.*);
	cmc_mem_model mem_u (.clk(CLK_SYS), .slow(slow), .ireq(IREQ_O),
		.ibreq(IBREQ_O), .dreq(DREQ_O), .rw(RW_O), .addr(ADDR_O),
		.wdata(DATA_O), .irdy(IRDY_I), .instr(INSTR_I), .drdy(DRDY_I),
		.rdata(rdata));

	task automatic check(input logic [BUS_W-1:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge CLK_SYS);
		#1;
	endtask

	task automatic access(input logic wr, input logic [BUS_W-1:0] a, d,
	                      output logic [BUS_W-1:0] q);
		int k;
		{CORE_DREQ, CORE_DWRITE, CORE_DADDR, CORE_DWDATA} = {1'b1, wr, a, d};
		#1;
		for (k = 0; CORE_DACK !== 1'b1 && k < 50; k++)
			tick(1);
		tick(1);
		CORE_DREQ = 0;
		for (k = 0; CORE_DVALID !== 1'b1 && k < 50; k++)
			tick(1);
		q = CORE_DRDATA;
	endtask

	task automatic t_stream;
		logic [BUS_W-1:0] e, q;
		int               k;
		e = RESET_VECTOR;
		CORE_IFREE = 1;
		fork
			repeat (12) begin
				for (k = 0; CORE_INSTR_VALID !== 1'b1 && k < 50; k++)
					tick(1);
				check(CORE_INSTR, e ^ 32'hffff_0000);
				e = e + WORD_STEP;
				tick(1);
			end
			begin
				// Data must overlap the running instruction burst
				tick(4);
				SUPERVISOR = 1;
				access(1, 32'h0000_0040, 32'hc0de_0001, q);
				SUPERVISOR = 0;
				access(0, 32'h0000_0040, '0, q);
				check(q, 32'hc0de_0001);
				{slow, CORE_DKIND} = {1'b1, KIND_PIPE};
				access(0, 32'h0000_0080, '0, q);
				check(q, ~32'h0000_0080);
			end
		join
		CORE_IFREE = 0;
		tick(6);
	endtask

	task automatic t_grant;
		int k;
		BREQ_I = 1;
		for (k = 0; BGRANT_O !== 1'b1 && k < 50; k++)
			tick(1);
		check(ADDR_OE, 0);
		BREQ_I = 0;
		tick(1);
		check(BGRANT_O, 0);
		fault = 1;
		tick(1);
		fault = 0;
		for (k = 0; OUT_ERR !== 1'b1 && k < 3; k++)
			tick(1);
		check(OUT_ERR, 1);
		tick(3);
		check(OUT_ERR, 0);
	endtask

	task automatic t_modes;
		logic [6:0] req [8] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h02,
		                        7'h01, 7'h7f};
		logic [2:0] exp [8] = '{STAT_RESET, STAT_TEST, STAT_STEP, STAT_HALT,
		                        STAT_LTI, STAT_HOLD, STAT_HOLD, STAT_RESET};
		for (int i = 0; i < 8; i++) begin
			{RESET_REQ, TEST_REQ, STEP_REQ, HALT_REQ, LTI_REQ, CORE_HAZARD,
			 CORE_NEED_INSTR} = req[i];
			tick(2);
			check(MODE_STATUS, exp[i]);
			{RESET_REQ, TEST_REQ, STEP_REQ, HALT_REQ, LTI_REQ, CORE_HAZARD,
			 CORE_NEED_INSTR} = '0;
			tick(2);
			check(MODE_STATUS, STAT_EXEC);
		end
	endtask

	task automatic t_events;
		WAIT_ENTER = 1;
		tick(1);
		WAIT_ENTER = 0;
		tick(4);
		check(MODE_STATUS, STAT_WAIT);
		INTR_REQ = 1;
		tick(1);
		INTR_REQ = 0;
		tick(1);
		check(MODE_STATUS, STAT_EXEC);
		HALT_INSTR = 1;
		tick(1);
		HALT_INSTR = 0;
		CORE_IFREE = 1;
		tick(5);
		check(MODE_STATUS, STAT_HALT);
		check(IREQ_O, 0);
		CORE_IFREE = 0;
		RESET_REQ = 1;
		tick(1);
		RESET_REQ = 0;
		tick(2);
		check(MODE_STATUS, STAT_EXEC);
		check(ADDR_O, RESET_VECTOR);
		STEP_REQ = 1;
		tick(3);
		STEP_GO = 1;
		tick(2);
		check(MODE_STATUS, STAT_EXEC);
		tick(1);
		check(MODE_STATUS, STAT_STEP);
		{STEP_GO, STEP_REQ} = '0;
		tick(2);
	endtask

	initial begin
		CLK_SYS = 0;
		forever #4 CLK_SYS = ~CLK_SYS;
	end

	// Hang guard, far above the hundred or so cycles needed
	always @(posedge CLK_SYS) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			conclude;
		end
	end

	initial begin
		{RESET_REQ, TEST_REQ, HALT_REQ, STEP_REQ, STEP_GO, LTI_REQ, HALT_INSTR,
		 WAIT_ENTER, INTR_REQ, CORE_HAZARD, CORE_NEED_INSTR, SUPERVISOR} = '0;
		{CORE_IFREE, CORE_BRANCH, CORE_DREQ, CORE_DWRITE, CORE_DCOP,
		 CORE_DMORE, BREQ_I, slow, fault, ARST_N} = '0;
		{CORE_DKIND, CORE_BRANCH_ADDR, CORE_DADDR, CORE_DWDATA,
		 CORE_COP_OPND} = '0;
		tick(16);
		ARST_N = 1;
		tick(2);
		t_stream;
		t_grant;
		t_modes;
		t_events;
		conclude;
	end
endmodule // tb

`default_nettype wire
